// ==== include/mmdt_pkg.sv ====
package mmdt_pkg;

    // timebase
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_LONG_MS   = 20;
    localparam int DEB_SHORT_MS  = 1;
    localparam int OS_UNIT_MS    = 10;

    // value limits
    localparam logic [13:0] SET_MAX       = 14'h270F;
    localparam logic [9:0]  CNT_UNIT_LAST = 10'h3E7;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_SET_A  = 12'h004;
    localparam logic [11:0] OFS_SET_B  = 12'h008;
    localparam logic [11:0] OFS_OSW    = 12'h00C;
    localparam logic [11:0] OFS_LIMIT  = 12'h010;
    localparam logic [11:0] OFS_ALARM0 = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h020;
    localparam logic [11:0] OFS_PV     = 12'h024;
    localparam logic [11:0] OFS_MON0   = 12'h028;
    localparam int          NUM_CNT    = 3;

    // control register fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_DOWN_BIT  = 4;
    localparam int CTRL_RANGE_LSB = 5;
    localparam int CTRL_DEB1_BIT  = 8;
    localparam int CTRL_BOTH_BIT  = 9;
    localparam int CTRL_RSTRT_BIT = 10;

    // values after reset
    localparam logic [13:0] LIMIT_RST = SET_MAX;
    localparam logic        BOOT_RST  = 1'b1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        MD_A, MD_A1, MD_A2, MD_A3, MD_B, MD_B1,
        MD_D, MD_E, MD_F, MD_Z, MD_S
    } mmdt_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_RUN   = 2'h1,
        ST_UP    = 2'h3,
        ST_PAUSE = 2'h2
    } mmdt_state_e;

    // length of one display digit in milliseconds per range code
    function automatic logic [21:0] mmdt_unit_ms(input logic [2:0] r);
        case (r)
            3'h0:    return 22'h000001;
            3'h1:    return 22'h00000A;
            3'h2:    return 22'h000064;
            3'h3:    return 22'h0003E8;
            3'h4:    return 22'h00EA60;
            3'h5:    return 22'h057E40;
            default: return 22'h36EE80;
        endcase
    endfunction

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } mmdt_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mmdt_axi_rsp_s;

    typedef struct packed {
        logic control_out;
        logic instant_output_a;
        logic instant_output_b;
        logic alarm_error;
        logic reset_indicator;
        logic hold_indicator;
        logic timing;
    } mmdt_out_s;

    typedef struct packed {
        mmdt_axi_rsp_s              rsp;
        mmdt_out_s                  o;
        mmdt_mode_e                 mode;
        logic                       down;
        logic [2:0]                 range;
        logic                       deb1;
        logic                       both;
        logic [13:0]                set_a, set_b, osw, limit;
        logic [NUM_CNT-1:0][13:0]   alarm, thou;
        logic [NUM_CNT-1:0][9:0]    sub;
        logic [NUM_CNT-1:0]         prev;
        logic [15:0]                pre;
        logic [21:0]                unit;
        logic [1:0][4:0]            deb;
        logic [1:0]                 lvl;
        logic                       boot;
        mmdt_state_e                st;
        logic [13:0]                cnt, frozen;
        logic                       freeze, phase, out;
        logic [16:0]                os;
    } mmdt_core_s;

endpackage

// ==== hw/mmdt_top.sv ====
// Function
// - time range 1 ms up to 9999 h
// - up shows elapsed, down shows remaining
// - eleven selectable output operating modes
// - one-shot width 0.01 to 99.99 s
// - one-shot only in A, A1-A3, B, B1, S
// - zero width means held output, flagged
// - shared 20 ms or 1 ms input debounce
// - set values clamped to upper limit, except on-duty
// - ON-count alarm in thousands, zero disables
// - error when control ON count exceeds alarm
// - separate alarms for both instantaneous outputs
// - read-only ON-count monitors in thousands
// - instantaneous or time-limit on second contacts
// - start already on starts timing at release
// - A, B, B1, Z ignore start while timing
// - A1 restarts on start, clears on release
// - power-on delays start at reset release, pause
// - zero set in delay/cumulative: output at once
// - repeat cycle toggles or pulses at time-up
// - off delay holds while start, times after
// - interval on at start, off at time-up
// - cumulative counts only while start, keeps value
// - A3, B1, F keep value across power cycle
// - reset input clears output, and present value unless a stopwatch is running
// - stopwatch start toggles, reset freezes display while running
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module mmdt_top #(
    parameter logic [15:0] MS_CYCLES = 16'(mmdt_pkg::MS_CYCLES)
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // register bus
    input  wire mmdt_pkg::mmdt_axi_req_s axi_req,
    output mmdt_pkg::mmdt_axi_rsp_s      axi_rsp,
    // field inputs
    input  wire logic              start_in,
    input  wire logic              reset_in,
    // field outputs
    output mmdt_pkg::mmdt_out_s    io_out
);
    import mmdt_pkg::*;

    mmdt_core_s  q;
    mmdt_core_s  d;
    logic        ms_tick;
    logic        tick;
    logic [21:0] unit_ms;
    logic [4:0]  deb_w;
    logic [1:0]  raw;
    logic        s;
    logic        r;
    logic        s_rise;
    logic        s_fall;
    logic        r_rel;
    logic [13:0] set_cur;
    logic [13:0] disp;
    logic [13:0] pv;
    logic        advance;
    logic        up_now;
    logic        os_ok;
    logic        start_ok;
    logic        keep;
    logic        err;
    logic [31:0] wval;
    logic [2:0]  new_o;

    assign axi_rsp = q.rsp;
    assign io_out  = q.o;

    function automatic logic [13:0] clamp(input logic [31:0] v,
                                          input logic [13:0] mx);
        return (v > {18'h0, mx}) ? mx : v[13:0];
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  st);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
        return m;
    endfunction

    function automatic logic [31:0] rdmux(input logic [11:0] a);
        logic [31:0] v;
        v = '0;
        case (a)
            OFS_CTRL: begin
                v[CTRL_MODE_LSB +: 4]  = q.mode;
                v[CTRL_DOWN_BIT]       = q.down;
                v[CTRL_RANGE_LSB +: 3] = q.range;
                v[CTRL_DEB1_BIT]       = q.deb1;
                v[CTRL_BOTH_BIT]       = q.both;
            end
            OFS_SET_A:  v[13:0] = q.set_a;
            OFS_SET_B:  v[13:0] = q.set_b;
            OFS_OSW:    v[13:0] = q.osw;
            OFS_LIMIT:  v[13:0] = q.limit;
            OFS_STATUS: v[6:0]  = {q.st, q.o.reset_indicator,
                                   q.o.alarm_error, q.o.hold_indicator,
                                   q.o.timing, q.o.control_out};
            OFS_PV:     v[13:0] = pv;
            default: begin
                for (int i = 0; i < NUM_CNT; i++) begin
                    if (a == OFS_ALARM0 + 12'(4 * i)) begin
                        v[13:0] = q.alarm[i];
                    end
                    // monitors show whole thousands only
                    if (a == OFS_MON0 + 12'(4 * i)) begin
                        v[13:0] = q.thou[i];
                    end
                end
            end
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        logic m;
        m = (a <= OFS_PV) || (a == OFS_MON0) ||
            (a == OFS_MON0 + 12'h004) || (a == OFS_MON0 + 12'h008);
        return m && (a[1:0] == 2'h0);
    endfunction

    always_comb begin
        d    = q;
        keep = 1'b0;

        // 1 ms base tick, then a divider to one display digit
        ms_tick = (q.pre == MS_CYCLES - 16'h0001);
        d.pre   = ms_tick ? 16'h0000 : q.pre + 16'h0001;
        unit_ms = mmdt_unit_ms(q.range);
        tick    = ms_tick && (q.unit == unit_ms - 22'h000001);
        if (ms_tick) begin
            d.unit = tick ? 22'h000000 : q.unit + 22'h000001;
        end

        // a level must stay put for the whole width to count
        raw   = {reset_in, start_in};
        deb_w = q.deb1 ? 5'(DEB_SHORT_MS) : 5'(DEB_LONG_MS);
        for (int i = 0; i < 2; i++) begin
            if (ms_tick) begin
                if (raw[i] == q.lvl[i]) begin
                    d.deb[i] = 5'h00;
                end else if (q.deb[i] + 5'h01 >= deb_w) begin
                    d.lvl[i] = raw[i];
                    d.deb[i] = 5'h00;
                end else begin
                    d.deb[i] = q.deb[i] + 5'h01;
                end
            end
        end
        s      = d.lvl[0];
        r      = d.lvl[1];
        s_rise = s & ~q.lvl[0];
        s_fall = ~s & q.lvl[0];
        r_rel  = ~r & (q.lvl[1] | q.boot);
        d.boot = q.boot & r;

        set_cur = (q.mode == MD_Z && q.phase) ? q.set_b : q.set_a;
        advance = tick && q.st == ST_RUN
                  && !((q.mode == MD_A2 || q.mode == MD_A3) && s)
                  && !(q.mode == MD_F && !s);
        // zero set value ends the interval at once
        up_now  = q.st == ST_RUN && q.mode != MD_S &&
                  (set_cur == 14'h0000 ||
                   (advance && q.cnt + 14'h0001 >= set_cur));
        os_ok   = q.osw != 14'h0000 &&
                  (q.mode <= MD_B1 || q.mode == MD_S);
        start_ok = r_rel && s;
        if (advance && q.cnt != SET_MAX) begin
            d.cnt = q.cnt + 14'h0001;
        end

        // one-shot width runs down in milliseconds
        if (q.os != 17'h00000 && ms_tick) begin
            d.os = q.os - 17'h00001;
            if (q.os == 17'h00001) begin
                d.out = 1'b0;
            end
        end

        if (r && !(q.mode == MD_S && q.st == ST_RUN)) begin
            // reset holds everything idle
            d.st     = ST_IDLE;
            d.cnt    = 14'h0000;
            d.out    = 1'b0;
            d.os     = 17'h00000;
            d.freeze = 1'b0;
            d.phase  = 1'b0;
        end else begin
            if (r && !q.freeze) begin
                d.frozen = q.cnt;
                d.freeze = 1'b1;
            end
            case (q.mode)
                MD_A, MD_A1, MD_B, MD_B1, MD_E, MD_Z: begin
                    // running timers ignore further starts
                    if (q.st == ST_IDLE && (s_rise || start_ok)) begin
                        d.st    = ST_RUN;
                        d.cnt   = 14'h0000;
                        d.phase = q.mode == MD_Z;
                        d.out   = (q.mode == MD_Z) ||
                                  (q.mode == MD_E && q.set_a != 0);
                    end
                    if (q.mode == MD_A1 && (s_fall || !s)) begin
                        d.st  = ST_IDLE;
                        d.cnt = 14'h0000;
                        d.out = 1'b0;
                        d.os  = 17'h00000;
                    end
                end
                MD_A2, MD_A3: begin
                    if (q.st == ST_IDLE && r_rel) begin
                        d.st  = ST_RUN;
                        d.cnt = 14'h0000;
                    end
                end
                MD_F: begin
                    if (q.st == ST_IDLE) begin
                        d.st = ST_RUN;
                    end
                end
                MD_D: begin
                    if (s) begin
                        d.st  = ST_IDLE;
                        d.cnt = 14'h0000;
                        d.out = 1'b1;
                    end else if (s_fall) begin
                        d.st  = ST_RUN;
                    end
                end
                MD_S: begin
                    if (s_rise) begin
                        d.st = (q.st == ST_RUN) ? ST_PAUSE : ST_RUN;
                    end
                    if (advance && q.cnt + 14'h0001 == q.set_a) begin
                        d.out = 1'b1;
                        d.os  = os_ok ? 17'(q.osw) * 17'(OS_UNIT_MS)
                                      : 17'h00000;
                    end
                end
                default: d.st = ST_IDLE;
            endcase

            if (up_now) begin
                case (q.mode)
                    MD_B, MD_B1, MD_Z: begin
                        d.cnt = 14'h0000;
                        if (os_ok) begin
                            d.out = 1'b1;
                            d.os  = 17'(q.osw) * 17'(OS_UNIT_MS);
                        end else begin
                            d.out = ~q.out;
                        end
                        d.phase = ~q.phase;
                    end
                    MD_E: begin
                        d.st  = ST_UP;
                        d.out = 1'b0;
                    end
                    MD_D: begin
                        if (!s) begin
                            d.st  = ST_IDLE;
                            d.cnt = 14'h0000;
                            d.out = 1'b0;
                        end
                    end
                    default: begin
                        d.st  = ST_UP;
                        d.out = 1'b1;
                        d.os  = os_ok ? 17'(q.osw) * 17'(OS_UNIT_MS)
                                      : 17'h00000;
                    end
                endcase
            end
            // a running stopwatch keeps counting, but the load stays off
            if (r) begin
                d.out = 1'b0;
                d.os  = 17'h00000;
            end
        end

        // present value seen by software
        disp = q.freeze ? q.frozen : q.cnt;
        if (!q.down) begin
            pv = disp;
        end else begin
            pv = (set_cur > disp) ? set_cur - disp : 14'h0000;
        end

        // outputs
        d.o.control_out      = d.out;
        d.o.instant_output_a = q.both ? d.out : d.st != ST_IDLE;
        d.o.instant_output_b = q.both ? d.out : s;
        d.o.reset_indicator  = r;
        d.o.hold_indicator   = q.osw == 14'h0000;
        d.o.timing           = d.st == ST_RUN;

        // ON counters of all three contacts
        new_o = {q.o.instant_output_b, q.o.instant_output_a,
                 q.o.control_out};
        err   = 1'b0;
        for (int i = 0; i < NUM_CNT; i++) begin
            d.prev[i] = new_o[i];
            if (new_o[i] && !q.prev[i] && q.thou[i] != SET_MAX) begin
                if (q.sub[i] == CNT_UNIT_LAST) begin
                    d.sub[i]  = 10'h000;
                    d.thou[i] = q.thou[i] + 14'h0001;
                end else begin
                    d.sub[i]  = q.sub[i] + 10'h001;
                end
            end
            // zero threshold disables the alarm
            if (q.alarm[i] != 14'h0000 &&
                (q.thou[i] > q.alarm[i] ||
                 (q.thou[i] == q.alarm[i] && q.sub[i] != 10'h000))) begin
                err = 1'b1;
            end
        end
        d.o.alarm_error = err;

        // register bus: address and data are taken together
        d.rsp.awready = 1'b0;
        d.rsp.wready  = 1'b0;
        d.rsp.arready = 1'b0;
        if (q.rsp.bvalid && axi_req.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        if (q.rsp.rvalid && axi_req.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (axi_req.awvalid && axi_req.wvalid && !q.rsp.awready &&
            !q.rsp.bvalid) begin
            d.rsp.awready = 1'b1;
            d.rsp.wready  = 1'b1;
        end
        wval = wmerge(rdmux(axi_req.awaddr), axi_req.wdata, axi_req.wstrb);
        if (q.rsp.awready) begin
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp  = mapped(axi_req.awaddr) ? RESP_OKAY : RESP_SLVERR;
            case (axi_req.awaddr)
                OFS_CTRL: begin
                    d.mode  = mmdt_mode_e'(wval[CTRL_MODE_LSB +: 4]);
                    d.down  = wval[CTRL_DOWN_BIT];
                    d.range = wval[CTRL_RANGE_LSB +: 3];
                    d.deb1  = wval[CTRL_DEB1_BIT];
                    d.both  = wval[CTRL_BOTH_BIT];
                    if (axi_req.wstrb[CTRL_RSTRT_BIT / 8] &&
                        axi_req.wdata[CTRL_RSTRT_BIT]) begin
                        // software power cycle; some modes keep counting
                        keep   = q.mode == MD_A3 || q.mode == MD_B1 ||
                                 q.mode == MD_F;
                        d.boot = 1'b1;
                        if (!keep) begin
                            d.st    = ST_IDLE;
                            d.cnt   = 14'h0000;
                            d.out   = 1'b0;
                            d.os    = 17'h00000;
                            d.phase = 1'b0;
                        end
                    end
                end
                OFS_SET_A: d.set_a = clamp(wval, q.limit);
                OFS_SET_B: d.set_b = q.mode == MD_Z ?
                                     clamp(wval, SET_MAX) :
                                     clamp(wval, q.limit);
                OFS_OSW:   d.osw   = clamp(wval, SET_MAX);
                OFS_LIMIT: d.limit = wval == 32'h0 ? 14'h0001 :
                                     clamp(wval, SET_MAX);
                default: begin
                    for (int i = 0; i < NUM_CNT; i++) begin
                        if (axi_req.awaddr == OFS_ALARM0 + 12'(4 * i)) begin
                            d.alarm[i] = clamp(wval, SET_MAX);
                        end
                    end
                end
            endcase
        end
        if (axi_req.arvalid && !q.rsp.arready && !q.rsp.rvalid) begin
            d.rsp.arready = 1'b1;
        end
        if (q.rsp.arready) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rdata  = rdmux(axi_req.araddr);
            d.rsp.rresp  = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q       <= '0;
            q.limit <= LIMIT_RST;
            q.boot  <= BOOT_RST;
        end else begin
            q <= d;
        end
    end

endmodule

// ==== verif/mmdt_monitor.sv ====
`timescale 1ns/1ps
module mmdt_monitor #(
    parameter logic [15:0] MS_CYCLES = 16'h0004
) (
    // clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // register bus
    input wire mmdt_pkg::mmdt_axi_req_s axi_req,
    input wire mmdt_pkg::mmdt_axi_rsp_s axi_rsp,
    // field side
    input wire logic                    start_in,
    input wire logic                    reset_in,
    input wire mmdt_pkg::mmdt_out_s     io_out
);
    import mmdt_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wr_answer;
        axi_rsp.awready && axi_rsp.wready |=> axi_rsp.bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
    property p_rd_answer;
        axi_rsp.arready |=> axi_rsp.rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
    property p_ar_pulse;
        axi_rsp.arready |=> !axi_rsp.arready;
    endproperty
    a_ar_pulse: assert property (p_ar_pulse) else $error("arready too long");
    property p_b_hold;
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid
            && $stable(axi_rsp.bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid
            && $stable(axi_rsp.rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_err_zero;
        axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR |-> axi_rsp.rdata == 0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error data seen");
    property p_rst_out;
        io_out.reset_indicator [*3] |-> !io_out.control_out;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("out during reset");
    property p_rst_follow;
        $rose(io_out.reset_indicator) |-> $past(reset_in)
            || $past(reset_in, 2) || $past(reset_in, 3);
    endproperty
    a_rst_follow: assert property (p_rst_follow) else $error("reset ghost");
    c_out: cover property ($rose(io_out.control_out));
    c_timing: cover property ($rose(io_out.timing));
    c_rst: cover property ($rose(io_out.reset_indicator));
endmodule

// ==== verif/mmdt_field.sv ====
`timescale 1ns/1ps
module mmdt_field (
    // clock
    input  wire logic aclk,
    // contact commands
    input  wire logic cmd_start,
    input  wire logic cmd_reset,
    // relay coil
    input  wire logic load_in,
    // contacts and relay count
    output logic      start_in = 1'b0,
    output logic      reset_in = 1'b0,
    output int        n_on = 0
);
    logic load_q = 1'b0;
    // contacts move just after the edge, never on it
    always @(posedge aclk) begin
        start_in <= cmd_start;
        reset_in <= cmd_reset;
        load_q   <= load_in;
        if (load_in === 1'b1 && load_q !== 1'b1) begin
            n_on <= n_on + 1;
        end
    end
endmodule

// ==== verif/multi_mode_delay_timer_tb_top.sv ====
`timescale 1ns/1ps
module multi_mode_delay_timer_tb_top;
    import mmdt_pkg::*;
    localparam int MSC = 4;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    mmdt_axi_req_s req = '0;
    mmdt_axi_rsp_s rsp;
    mmdt_out_s     io;
    logic          cmd_start = 1'b0;
    logic          cmd_reset = 1'b0;
    logic          start_in;
    logic          reset_in;
    int            n_on;
    int            mismatches = 0;
    int            n_compared = 0;
    int            n;
    int            setv;
    logic [33:0]   exp_q[$];
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    mmdt_top #(.MS_CYCLES(16'(MSC))) mmdt_top_i (.aclk(aclk),
        .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .start_in(start_in), .reset_in(reset_in), .io_out(io));
    mmdt_field mmdt_field_i (.aclk(aclk), .cmd_start(cmd_start),
        .cmd_reset(cmd_reset), .load_in(io.control_out),
        .start_in(start_in), .reset_in(reset_in), .n_on(n_on));
    function automatic logic [33:0] okv(input logic [13:0] v);
        return {RESP_OKAY, 18'h0, v};
    endfunction
    task automatic chk(input string s, input logic [33:0] e, g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        do @(posedge aclk); while (rsp.awready !== 1'b1);
        req.awvalid <= 1'b0;
        req.wvalid  <= 1'b0;
        // late ready makes the slave hold its answer one cycle
        @(posedge aclk);
        req.bready <= 1'b1;
        do @(posedge aclk); while (rsp.bvalid !== 1'b1);
        chk("bresp", 34'(RESP_OKAY), 34'(rsp.bresp));
        req.bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        @(posedge aclk);
        req.rready <= 1'b1;
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wait_on(input int sel);
        n = 0;
        while ((sel ? io.control_out : io.timing) !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
    endtask
    always @(posedge aclk) begin
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
            chk("rdata", exp_q.pop_front(), {rsp.rresp, rsp.rdata});
        end
    end
    initial begin
        void'($urandom(55960));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("hold", 34'h1, 34'(io.hold_indicator));
        rd(OFS_CTRL, okv(14'h0));
        rd(OFS_LIMIT, okv(LIMIT_RST));
        rd(12'h040, {RESP_SLVERR, 32'h0});
        wr(OFS_MON0, 32'h5);
        rd(OFS_MON0, okv(14'h0));
        wr(OFS_LIMIT, 32'h64);
        wr(OFS_SET_A, 32'hC8);
        rd(OFS_SET_A, okv(14'h64));
        wr(OFS_LIMIT, 32'h0);
        rd(OFS_LIMIT, okv(14'h1));
        for (int m = 0; m < 11; m++) begin
            wr(OFS_CTRL, 32'(m));
            rd(OFS_CTRL, okv(14'(m)));
        end
        // 10 ms closure against the 20 ms filter
        // power cycle ends the run left over from the mode sweep
        wr(OFS_CTRL, 32'h400);
        wr(OFS_LIMIT, 32'h270F);
        cmd_start <= 1'b1;
        repeat (10 * MSC) @(posedge aclk);
        cmd_start <= 1'b0;
        repeat (25 * MSC) @(posedge aclk);
        chk("timing", 34'h0, 34'(io.timing));
        setv = 3 + $urandom % 5;
        wr(OFS_SET_A, 32'(setv));
        wr(OFS_CTRL, 32'h100);
        cmd_start <= 1'b1;
        wait_on(0);
        chk("timing", 34'h1, 34'(io.timing));
        wait_on(1);
        chk("delay", 34'h1, 34'(n >= (setv - 1) * MSC && n <= (setv + 1) * MSC));
        cmd_reset <= 1'b1;
        repeat (5 * MSC) @(posedge aclk);
        chk("out", 34'h0, 34'(io.control_out));
        chk("rstind", 34'h1, 34'(io.reset_indicator));
        rd(OFS_PV, okv(14'h0));
        cmd_reset <= 1'b0;
        wait_on(0);
        chk("timing", 34'h1, 34'(io.timing));
        chk("inst_a", 34'h1, 34'(io.instant_output_a));
        chk("inst_b", 34'h1, 34'(io.instant_output_b));
        wait_on(1);
        @(posedge aclk);
        chk("load", 34'h2, 34'(n_on));
        chk("alarm", 34'h0, 34'(io.alarm_error));
        rd(OFS_MON0, okv(14'(n_on / 1000)));
        stop_test;
    end
    initial begin
        #100us;
        mismatches++;
        stop_test;
    end
endmodule
bind mmdt_top mmdt_monitor #(.MS_CYCLES(MS_CYCLES)) mmdt_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .start_in(start_in), .reset_in(reset_in), .io_out(io_out));
